// >>> common/sfbg_pkg.sv
// Constants, carrier types and the shared format function of the
// serial format and bit-rate block.
// Assumes a single 10 MHz clock domain and an AXI4-Lite register port.
package sfbg_pkg;

  // ********************************************************************
  // Register map (byte addresses, one aligned word each)
  // ********************************************************************
  localparam logic [3:0] OFF_FMT = 4'h0;
  localparam logic [3:0] OFF_RATE = 4'h4;
  localparam logic [3:0] OFF_SMC = 4'h8;
  localparam logic [3:0] OFF_STAT = 4'hC;

  // ********************************************************************
  // Field positions and reset values
  // ********************************************************************
  localparam int FMT_DIR_BIT = 3;
  localparam int FMT_INV_BIT = 2;
  localparam int FMT_MODE_BIT = 0;
  localparam logic [7:0] FMT_RSVD_ONES = 8'hF2;
  localparam logic [7:0] FMT_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'hFF;
  localparam logic [7:0] SMC_RESET = 8'h00;
  localparam int SMC_CKS_LO_BIT = 0;
  localparam int SMC_CKS_HI_BIT = 1;
  localparam int SMC_PAR_ODD_BIT = 4;
  localparam int SMC_CHR7_BIT = 6;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // ********************************************************************
  // Bus responses and generator stages
  // ********************************************************************
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [4:0] FINAL_DIV_LAST = 5'h1F;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // Configuration that steers the generator and the format stage
  typedef struct packed {
    logic msb_first;
    logic invert;
    logic chr7;
    logic [1:0] cks;
    logic [7:0] divn;
  } sfbg_cfg_s;

  // Reorder and invert one character; both steps are self-inverse,
  // so the same function serves transmit and receive.
  function automatic logic [7:0] fmt_word(input logic [7:0] d,
                                          input logic msb_first,
                                          input logic chr7,
                                          input logic invert);
    logic [7:0] r;
    r = d;
    if (msb_first && !chr7) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = d[7 - i];
      end
    end
    if (invert) begin
      r = chr7 ? {r[7], ~r[6:0]} : ~r;
    end
    return r;
  endfunction : fmt_word

  // Prescaler terminal count for a divide by 4 to the power n
  function automatic logic [5:0] pre_last(input logic [1:0] n);
    logic [5:0] v;
    v = 6'h00;
    unique case (n)
      2'd0: v = 6'h00;
      2'd1: v = 6'h03;
      2'd2: v = 6'h0F;
      2'd3: v = 6'h3F;
    endcase
    return v;
  endfunction : pre_last

endpackage : sfbg_pkg

// >>> design/sfbg_baud_gen.sv
// Bit-rate generator: 4^n prescaler, (N+1) divider, fixed divide by 32.
// Assumes configuration from logic on the same clock.
`timescale 1ns/1ps
module sfbg_baud_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire sfbg_pkg::sfbg_cfg_s cfg,
  output logic sample_tick_r,
  output logic bit_tick_r
);

  logic [5:0] pre_cnt_r;
  logic [7:0] div_cnt_r;
  logic [4:0] fin_cnt_r;
  logic pre_tick;
  logic div_tick;

  // Stage terminal conditions
  assign pre_tick = (pre_cnt_r == sfbg_pkg::pre_last(cfg.cks));
  assign div_tick = pre_tick && (div_cnt_r == 8'h00);

  // Prescaler divides the clock by 4 to the power n
  always_ff @(posedge aclk) begin
    if (!aresetn || restart || pre_tick) begin
      pre_cnt_r <= 6'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
    end
  end

  // Down counter reloaded with N divides by N+1, N=0 included
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      div_cnt_r <= cfg.divn;
    end else if (pre_tick) begin
      div_cnt_r <= div_tick ? cfg.divn : div_cnt_r - 8'h01;
    end
  end

  // Final divide by 32 yields one bit period
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      fin_cnt_r <= 5'h00;
    end else if (div_tick) begin
      fin_cnt_r <= fin_cnt_r + 5'h01;
    end
  end

  // Registered tick outputs
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      sample_tick_r <= 1'b0;
      bit_tick_r <= 1'b0;
    end else begin
      sample_tick_r <= div_tick;
      bit_tick_r <= div_tick && (fin_cnt_r == sfbg_pkg::FINAL_DIV_LAST);
    end
  end

endmodule : sfbg_baud_gen

// >>> design/sfbg_format.sv
// Format stage: bit order and level inversion for both directions.
// Assumes words arrive from the shifters on the same clock.
`timescale 1ns/1ps
module sfbg_format (
  input wire logic aclk,
  input wire logic aresetn,
  input wire sfbg_pkg::sfbg_cfg_s cfg,
  input wire logic [7:0] tx_hold_data,
  input wire logic [7:0] rx_shift_data,
  output logic [7:0] tx_line_data_r,
  output logic [7:0] rx_store_data_r
);

  // Transmit word: holding buffer to shifter order and level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_line_data_r <= 8'h00;
    end else begin
      tx_line_data_r <= sfbg_pkg::fmt_word(tx_hold_data, cfg.msb_first,
                                           cfg.chr7, cfg.invert);
    end
  end

  // Receive word: shifter order and level to holding buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_store_data_r <= 8'h00;
    end else begin
      rx_store_data_r <= sfbg_pkg::fmt_word(rx_shift_data, cfg.msb_first,
                                            cfg.chr7, cfg.invert);
    end
  end

endmodule : sfbg_format

// >>> design/sfbg_top.sv
// Top of one channel's serial format options and bit-rate generator,
// with its AXI4-Lite register slave.
// Assumes one clock, synchronous reset, shifters on the same clock.
//
// Summary of operation
// - Direction bit 0 LSB-first, 1 MSB-first
// - Seven-bit characters always LSB-first
// - Invert bit flips data both directions
// - Parity level never inverted; software flips parity
// - Reserved format bits read one, ignore writes
// - Eight-bit rate register, resets all ones
// - Each channel has its own generator
// - Rate is clock over 64*2^(2n-1)*(N+1)
// - Clock-select bits give prescale exponent n
// - Every N from 0 to 255 valid
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module sfbg_top (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Shifter side
  input wire logic [7:0] tx_hold_data,
  input wire logic [7:0] rx_shift_data,
  output logic [7:0] tx_line_data,
  output logic [7:0] rx_store_data,
  output logic chr7_sel,
  output logic parity_odd_sel,
  output logic sample_tick,
  output logic bit_tick
);

  // ********************************************************************
  // Register state
  // ********************************************************************
  logic fmt_dir_r;
  logic fmt_inv_r;
  logic fmt_mode_r;
  logic [7:0] rate_r;
  logic [7:0] smc_r;
  logic [7:0] period_cnt_r;
  logic chr7_r;
  logic par_odd_r;

  // Bus state
  logic aw_held_r;
  logic [3:0] aw_addr_r;
  logic w_held_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic do_write;
  logic wr_fmt;
  logic wr_rate;
  logic wr_smc;
  logic wr_map;
  logic rate_restart;
  logic bit_tick_i;
  logic [7:0] fmt_rd;
  sfbg_pkg::sfbg_cfg_s cfg;

  // Address map check, shared by both directions
  function automatic logic is_mapped(input logic [3:0] a);
    return (a == sfbg_pkg::OFF_FMT) || (a == sfbg_pkg::OFF_RATE) ||
           (a == sfbg_pkg::OFF_SMC) || (a == sfbg_pkg::OFF_STAT);
  endfunction : is_mapped

  // ********************************************************************
  // AXI4-Lite write path
  // ********************************************************************

  // Write commits once address and data are both held
  assign do_write = aw_held_r && w_held_r && !bvalid_r;
  assign wr_map = is_mapped(aw_addr_r);
  assign wr_fmt = do_write && w_lane_r && (aw_addr_r == sfbg_pkg::OFF_FMT);
  assign wr_rate = do_write && w_lane_r && (aw_addr_r == sfbg_pkg::OFF_RATE);
  assign wr_smc = do_write && w_lane_r && (aw_addr_r == sfbg_pkg::OFF_SMC);

  // Address channel, accepted independently of data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  // Data channel; only the low byte lane carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata[7:0];
      w_lane_r <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response, SLVERR for an unmapped address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= sfbg_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_map ? sfbg_pkg::RESP_OKAY : sfbg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Ready held low while a channel is stored or a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !bvalid_r && !do_write &&
                       !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !bvalid_r && !do_write &&
                      !(s_axi_wvalid && s_axi_wready);
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************

  // Format/mode control; reserved bits have no storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fmt_dir_r <= sfbg_pkg::FMT_RESET[sfbg_pkg::FMT_DIR_BIT];
      fmt_inv_r <= sfbg_pkg::FMT_RESET[sfbg_pkg::FMT_INV_BIT];
      fmt_mode_r <= sfbg_pkg::FMT_RESET[sfbg_pkg::FMT_MODE_BIT];
    end else if (wr_fmt) begin
      fmt_dir_r <= w_data_r[sfbg_pkg::FMT_DIR_BIT];
      fmt_inv_r <= w_data_r[sfbg_pkg::FMT_INV_BIT];
      fmt_mode_r <= w_data_r[sfbg_pkg::FMT_MODE_BIT];
    end
  end

  // Bit-rate setting, writable at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_r <= sfbg_pkg::RATE_RESET;
    end else if (wr_rate) begin
      rate_r <= w_data_r;
    end
  end

  // Serial mode control: clock select, parity sense, character length
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      smc_r <= sfbg_pkg::SMC_RESET;
    end else if (wr_smc) begin
      smc_r <= w_data_r;
    end
  end

  // Count of bit periods, readable as generator status
  always_ff @(posedge aclk) begin
    if (!aresetn || rate_restart) begin
      period_cnt_r <= sfbg_pkg::STAT_RESET;
    end else if (bit_tick_i) begin
      period_cnt_r <= period_cnt_r + 8'h01;
    end
  end

  // Generator restarts on any change of its divide settings
  assign rate_restart = wr_rate || wr_smc;

  // ********************************************************************
  // AXI4-Lite read path
  // ********************************************************************

  // Reserved format bits always read as one
  assign fmt_rd = sfbg_pkg::FMT_RSVD_ONES |
                  ({7'h00, fmt_dir_r} << sfbg_pkg::FMT_DIR_BIT) |
                  ({7'h00, fmt_inv_r} << sfbg_pkg::FMT_INV_BIT) |
                  ({7'h00, fmt_mode_r} << sfbg_pkg::FMT_MODE_BIT);

  // One read at a time: address taken, data returned next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else begin
      arready_r <= !rvalid_r && !(s_axi_arvalid && arready_r);
    end
  end

  // Read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= sfbg_pkg::RD_ZERO;
      rresp_r <= sfbg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      rvalid_r <= 1'b1;
      rresp_r <= is_mapped(s_axi_araddr) ? sfbg_pkg::RESP_OKAY
                                         : sfbg_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        sfbg_pkg::OFF_FMT: rdata_r <= {24'h00_0000, fmt_rd};
        sfbg_pkg::OFF_RATE: rdata_r <= {24'h00_0000, rate_r};
        sfbg_pkg::OFF_SMC: rdata_r <= {24'h00_0000, smc_r};
        sfbg_pkg::OFF_STAT: rdata_r <= {24'h00_0000, period_cnt_r};
        default: rdata_r <= sfbg_pkg::RD_ZERO;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ********************************************************************
  // Datapath configuration and sub-blocks
  // ********************************************************************

  // Direction honoured only for eight-bit characters
  always_comb begin
    cfg.msb_first = fmt_dir_r;
    cfg.invert = fmt_inv_r;
    cfg.chr7 = smc_r[sfbg_pkg::SMC_CHR7_BIT];
    cfg.cks = {smc_r[sfbg_pkg::SMC_CKS_HI_BIT],
               smc_r[sfbg_pkg::SMC_CKS_LO_BIT]};
    cfg.divn = rate_r;
  end

  // Parity sense passes straight through; inversion never touches it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chr7_r <= 1'b0;
      par_odd_r <= 1'b0;
    end else begin
      chr7_r <= cfg.chr7;
      par_odd_r <= smc_r[sfbg_pkg::SMC_PAR_ODD_BIT];
    end
  end

  assign chr7_sel = chr7_r;
  assign parity_odd_sel = par_odd_r;
  assign bit_tick = bit_tick_i;

  // Private generator for this channel
  sfbg_baud_gen u_baud_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(rate_restart),
    .cfg(cfg),
    .sample_tick_r(sample_tick),
    .bit_tick_r(bit_tick_i)
  );

  // Bit order and inversion for both directions
  sfbg_format u_format (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg),
    .tx_hold_data(tx_hold_data),
    .rx_shift_data(rx_shift_data),
    .tx_line_data_r(tx_line_data),
    .rx_store_data_r(rx_store_data)
  );

endmodule : sfbg_top

// >>> tb/sfbg_monitor.sv
// Checker of the serial format and bit-rate block ports.
// Assumes sfbg_top, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module sfbg_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] tx_hold_data,
  input wire logic [7:0] rx_shift_data,
  input wire logic [7:0] tx_line_data,
  input wire logic [7:0] rx_store_data,
  input wire logic chr7_sel,
  input wire logic sample_tick,
  input wire logic bit_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ******************************
  // Helper state
  // ******************************
  logic [3:0] wa_r;
  logic [3:0] ra_r;
  logic bv_r;
  logic seen_r;
  logic [5:0] cnt_r;
  logic rst_gen;
  // Generator restarts when a rate or mode write commits
  assign rst_gen = s_axi_bvalid && !bv_r &&
    (wa_r == sfbg_pkg::OFF_RATE || wa_r == sfbg_pkg::OFF_SMC);
  // Addresses of the transfers under way
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  // Last response valid, to spot its rise
  always_ff @(posedge aclk) begin
    bv_r <= aresetn && s_axi_bvalid;
  end
  // Sample ticks since the last bit tick
  always_ff @(posedge aclk) begin
    if (!aresetn || rst_gen) begin
      cnt_r <= 6'h00;
      seen_r <= 1'b0;
    end else if (bit_tick) begin
      cnt_r <= 6'h00;
      seen_r <= 1'b1;
    end else if (sample_tick) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  // ******************************
  // Assertions
  // ******************************
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  fmt_reserved_a: assert property (s_axi_rvalid &&
    ra_r == sfbg_pkg::OFF_FMT |-> s_axi_rdata[7:4] == 4'hF &&
    s_axi_rdata[1] && s_axi_rresp == sfbg_pkg::RESP_OKAY)
    else $error("reserved format bits not one");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] ==
    24'h00_0000) else $error("upper read bits set");
  same_format_a: assert property ($past(tx_hold_data) ==
    $past(rx_shift_data) |-> tx_line_data == rx_store_data)
    else $error("directions formatted differently");
  chr7_bit7_a: assert property (chr7_sel && $past(chr7_sel) &&
    $past(chr7_sel, 2) |-> tx_line_data[7] == $past(tx_hold_data[7]))
    else $error("seven-bit top bit moved");
  bit_on_sample_a: assert property (bit_tick |-> sample_tick)
    else $error("bit tick without sample tick");
  bit_count_a: assert property (bit_tick && seen_r |->
    cnt_r == 6'd31) else $error("bit tick not every 32 samples");
  cover property (bit_tick && seen_r);
  cover property (s_axi_rvalid && s_axi_rresp == sfbg_pkg::RESP_SLVERR);
  cover property (chr7_sel && tx_line_data != 8'h00);
endmodule : sfbg_monitor

bind sfbg_top sfbg_monitor i_mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .tx_hold_data(tx_hold_data),
  .rx_shift_data(rx_shift_data), .tx_line_data(tx_line_data),
  .rx_store_data(rx_store_data), .chr7_sel(chr7_sel),
  .sample_tick(sample_tick), .bit_tick(bit_tick));

// >>> tb/tb.sv
// Self-checking bench of the serial format and bit-rate block.
// Assumes sfbg_top and its monitor bound in; 10 MHz clock.
`timescale 1ns/1ps
module tb;
  logic aclk;
  logic aresetn;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic [7:0] txh, rxs, txl, rxd;
  logic chr7, par, stk, btk;
  int failures;
  int checks;
  sfbg_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_hold_data(txh),
    .rx_shift_data(rxs), .tx_line_data(txl), .rx_store_data(rxd),
    .chr7_sel(chr7), .parity_odd_sel(par), .sample_tick(stk),
    .bit_tick(btk));
  // ******************************
  // Bench tasks
  // ******************************
  task automatic end_sim;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bus write; address and data offered together
  task automatic wchk(input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, er);
    bready <= 1'b0;
  endtask : wchk
  // Bus read, compared with the expected byte and response
  task automatic rchk(input logic [3:0] a, input logic [7:0] e,
                      input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, {24'h00_0000, e});
    chk(rresp, er);
    rready <= 1'b0;
  endtask : rchk
  // Cycles between two consecutive ticks
  task automatic period(input logic b, output int p);
    p = 0;
    do @(posedge aclk); while (!(b ? btk : stk));
    do begin
      @(posedge aclk);
      p++;
    end while (!(b ? btk : stk));
  endtask : period
  function automatic logic [7:0] exp_fmt(input logic [7:0] d,
      input logic dir, input logic c7, input logic inv);
    logic [7:0] r;
    r = (dir && !c7) ? {<<{d}} : d;
    if (inv) r = c7 ? {r[7], ~r[6:0]} : ~r;
    return r;
  endfunction : exp_fmt
  // ******************************
  // Clock, watchdog and tests
  // ******************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Cuts a hang short
  initial begin
    #(100000 * 100);
    failures++;
    end_sim();
  end
  // Main sequence
  initial begin : main
    logic [7:0] v, fv, sv;
    logic [7:0] nt [5];
    int p;
    nt = '{8'h00, 8'h02, 8'h05, 8'h01, 8'hFF};
    {awaddr, araddr, wstrb, wdata, txh, rxs} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    aresetn = 1'b0;
    failures = 0;
    checks = 0;
    void'($urandom(30));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(sfbg_pkg::OFF_FMT, 8'hF2, sfbg_pkg::RESP_OKAY);
    rchk(sfbg_pkg::OFF_RATE, 8'hFF, sfbg_pkg::RESP_OKAY);
    wchk(sfbg_pkg::OFF_FMT, 8'h0E, 4'h1, sfbg_pkg::RESP_OKAY);
    rchk(sfbg_pkg::OFF_FMT, 8'hFE, sfbg_pkg::RESP_OKAY);
    wchk(4'h2, 8'h55, 4'h1, sfbg_pkg::RESP_SLVERR);
    rchk(4'h2, 8'h00, sfbg_pkg::RESP_SLVERR);
    v = 8'($urandom);
    wchk(sfbg_pkg::OFF_RATE, v, 4'h1, sfbg_pkg::RESP_OKAY);
    rchk(sfbg_pkg::OFF_RATE, v, sfbg_pkg::RESP_OKAY);
    wchk(sfbg_pkg::OFF_RATE, ~v, 4'h0, sfbg_pkg::RESP_OKAY);
    rchk(sfbg_pkg::OFF_RATE, v, sfbg_pkg::RESP_OKAY);
    // Every direction, inversion and length combination
    for (int k = 0; k < 8; k++) begin
      fv = {4'h0, k[0], k[1], 2'b00};
      sv = {1'b0, k[2], 1'b0, 1'($urandom), 4'h0};
      wchk(sfbg_pkg::OFF_FMT, fv, 4'h1, sfbg_pkg::RESP_OKAY);
      wchk(sfbg_pkg::OFF_SMC, sv, 4'h1, sfbg_pkg::RESP_OKAY);
      rchk(sfbg_pkg::OFF_FMT, fv | 8'hF2, sfbg_pkg::RESP_OKAY);
      for (int j = 0; j < 5; j++) begin
        v = (j == 0) ? 8'h01 : 8'($urandom);
        @(posedge aclk);
        txh <= v;
        rxs <= j[0] ? ~v : v;
        repeat (3) @(posedge aclk);
        chk(txl, exp_fmt(v, k[0], k[2], k[1]));
        chk(rxd, exp_fmt(rxs, k[0], k[2], k[1]));
      end
      chk(chr7, k[2]);
      chk(par, sv[4]);
    end
    // Rate for every prescale and divider boundaries
    for (int k = 0; k < 5; k++) begin
      sv = {6'h00, 2'(k % 4)};
      wchk(sfbg_pkg::OFF_SMC, sv, 4'h1, sfbg_pkg::RESP_OKAY);
      wchk(sfbg_pkg::OFF_RATE, nt[k], 4'h1, sfbg_pkg::RESP_OKAY);
      rchk(sfbg_pkg::OFF_SMC, sv, sfbg_pkg::RESP_OKAY);
      period(1'b0, p);
      chk(p, (4 ** (k % 4)) * (nt[k] + 1));
      period(1'b1, p);
      chk(p, 32 * (4 ** (k % 4)) * (nt[k] + 1));
      // Two bit periods counted since the restart
      rchk(sfbg_pkg::OFF_STAT, 8'h02, sfbg_pkg::RESP_OKAY);
    end
    end_sim();
  end
endmodule : tb
